//--- shared/viu_pkg.sv
package viu_pkg;
    localparam int         VIU_NSRC      = 32;
    localparam int         VIU_ADDR_W    = 9;
    localparam logic [8:0] VIU_OFF_MODE  = 9'h000;
    localparam logic [8:0] VIU_OFF_HNDL  = 9'h080;
    localparam logic [8:0] VIU_OFF_NVEC  = 9'h100;
    localparam logic [8:0] VIU_OFF_FVEC  = 9'h104;
    localparam logic [8:0] VIU_OFF_CUR   = 9'h108;
    localparam logic [8:0] VIU_OFF_PEND  = 9'h10c;
    localparam logic [8:0] VIU_OFF_ENA   = 9'h110;
    localparam logic [8:0] VIU_OFF_CORE  = 9'h114;
    localparam logic [8:0] VIU_OFF_ENCMD = 9'h120;
    localparam logic [8:0] VIU_OFF_DISCMD = 9'h124;
    localparam logic [8:0] VIU_OFF_CLRCMD = 9'h128;
    localparam logic [8:0] VIU_OFF_SETCMD = 9'h12c;
    localparam logic [8:0] VIU_OFF_EOS   = 9'h130;
    localparam logic [8:0] VIU_OFF_SPUR  = 9'h134;
    localparam int         VIU_PRIO_LSB  = 0;
    localparam int         VIU_TRIG_LSB  = 5;
    localparam logic [31:0] VIU_EXT_MASK = 32'h3000_0001;
    localparam logic [31:0] VIU_WORD_RST = 32'h0000_0000;
    localparam int         VIU_STK_DEPTH = 8;
    localparam logic [3:0] VIU_STK_FULL  = 4'h8;
endpackage

//--- design/viu_top.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module viu_top
    import viu_pkg::*;
(
    input  wire logic        ref_clk,               // 200 MHz clock
    input  wire logic        rst_b,                 // Async reset, low
    input  wire logic [8:0]  addr,                  // Register byte address
    input  wire logic        wr_en,                 // Write strobe
    input  wire logic        rd_en,                 // Read strobe
    input  wire logic [31:0] wdata,                 // Write data
    output logic      [31:0] rd_data,               // Read data, cycle after
    input  wire logic [31:0] src_in,                // Interrupt sources
    output logic             normal_request_line_n, // Normal request, low
    output logic             fast_request_line_n    // Fast request, low
);

    typedef struct packed {
        logic [VIU_NSRC-1:0][2:0]  prio;
        logic [VIU_NSRC-1:0][1:0]  trig;
        logic [VIU_NSRC-1:0][31:0] handler_address;
        logic [31:0]               spur_vec;
        logic [31:0]               ena;
        logic [31:0]               edge_pend;
        logic [31:0]               sy1;
        logic [31:0]               sy2;
        logic [31:0]               prev;
        logic [VIU_STK_DEPTH-1:0][7:0] stack;
        logic [3:0]                depth;
        logic                      spur;
        logic                      irq_n;
        logic                      fiq_n;
        logic [31:0]               rdata;
    } viu_state_t;

    viu_state_t s_q;
    viu_state_t s_d;

    logic [31:0] src_now;
    logic [31:0] lvl_act;
    logic [31:0] edge_det;
    logic [31:0] is_edge;
    logic [31:0] pend;
    logic        best_ok;
    logic [4:0]  best_idx;
    logic [2:0]  best_prio;
    logic [2:0]  top_idx;
    logic [2:0]  cur_prio;
    logic [4:0]  cur_src;
    logic        irq_want;
    logic        fiq_want;
    logic [6:0]  widx;

    assign widx    = addr[8:2];
    assign top_idx = 3'(s_q.depth - 4'h1);
    assign cur_prio = s_q.stack[top_idx][2:0];
    assign cur_src  = s_q.stack[top_idx][7:3];

    // Per-source detection; only external pins (VIU_EXT_MASK) go through the synchroniser
    for (genvar i = 0; i < VIU_NSRC; i++) begin : g_src
        logic hi;
        logic x;
        logic p;
        assign x  = VIU_EXT_MASK[i] ? s_q.sy2[i] : src_in[i];
        assign src_now[i] = x;
        assign p  = s_q.prev[i];
        assign hi = s_q.trig[i][1] | ~VIU_EXT_MASK[i];
        assign lvl_act[i]  = hi ? x : ~x;
        assign edge_det[i] = hi ? (x & ~p) : (~x & p);
        assign is_edge[i]  = s_q.trig[i][0];
        assign pend[i] = is_edge[i] ? s_q.edge_pend[i] : lvl_act[i];
        // Selection checks per normal source
        if (i != 0) begin : g_chk
            property p_urgency;
                @(posedge ref_clk) disable iff (!rst_b)
                pend[i] && s_q.ena[i] |-> best_ok && best_prio >= s_q.prio[i];
            endproperty
            a_urgency: assert property (p_urgency) else $error("lower urgency chosen");
            property p_tie;
                @(posedge ref_clk) disable iff (!rst_b)
                pend[i] && s_q.ena[i] && s_q.prio[i] == best_prio |-> best_idx <= 5'(i);
            endproperty
            a_tie: assert property (p_tie) else $error("tie not to lowest source");
        end
    end

    // Highest urgency wins, lowest source number on a tie
    always_comb begin
        best_ok   = 1'b0;
        best_idx  = 5'h00;
        best_prio = 3'h0;
        for (int i = 1; i < VIU_NSRC; i++) begin
            if (pend[i] && s_q.ena[i] && (!best_ok || s_q.prio[i] > best_prio)) begin
                best_ok   = 1'b1;
                best_idx  = 5'(i);
                best_prio = s_q.prio[i];
            end
        end
    end

    // Lines follow live state, so a vanished source drops them on the next clock
    assign irq_want = best_ok && !s_q.spur &&
                      (s_q.depth == 4'h0 || best_prio > cur_prio);
    assign fiq_want = pend[0] && s_q.ena[0] && !s_q.spur;

    always_comb begin
        logic [31:0] set_m;
        logic [31:0] clr_m;
        logic        nack;
        logic        fack;
        s_d   = s_q;
        set_m = edge_det;
        clr_m = 32'h0000_0000;
        nack  = !s_q.irq_n && irq_want;
        fack  = !s_q.fiq_n && fiq_want;
        s_d.sy1   = src_in;
        s_d.sy2   = s_q.sy1;
        s_d.prev  = src_now;
        s_d.rdata = VIU_WORD_RST;

        if (wr_en) begin
            if (addr < VIU_OFF_HNDL) begin
                s_d.prio[widx[4:0]] = wdata[VIU_PRIO_LSB +: 3];
                s_d.trig[widx[4:0]] = wdata[VIU_TRIG_LSB +: 2] &
                                      {VIU_EXT_MASK[widx[4:0]], 1'b1};
            end else if (addr < VIU_OFF_NVEC) begin
                s_d.handler_address[widx[4:0]] = wdata;
            end else begin
                case (addr)
                    VIU_OFF_ENCMD:  s_d.ena = s_q.ena | wdata;
                    VIU_OFF_DISCMD: s_d.ena = s_q.ena & ~wdata;
                    VIU_OFF_CLRCMD: clr_m = wdata;
                    VIU_OFF_SETCMD: set_m = edge_det | wdata;
                    VIU_OFF_SPUR:   s_d.spur_vec = wdata;
                    VIU_OFF_EOS: begin
                        if (s_q.spur) begin
                            s_d.spur = 1'b0;
                        end else if (s_q.depth != 4'h0) begin
                            s_d.depth = s_q.depth - 4'h1;
                        end
                    end
                    default: ;
                endcase
            end
        end

        if (rd_en) begin
            if (addr < VIU_OFF_HNDL) begin
                s_d.rdata = {25'h0, s_q.trig[widx[4:0]], 2'h0,
                             s_q.prio[widx[4:0]]};
            end else if (addr < VIU_OFF_NVEC) begin
                s_d.rdata = s_q.handler_address[widx[4:0]];
            end else begin
                case (addr)
                    VIU_OFF_NVEC: begin
                        // A read with the normal line asserted and irq_want still true acknowledges, a debug probe included
                        if (nack) begin
                            s_d.rdata = s_q.handler_address[best_idx];
                            clr_m[best_idx] = 1'b1;
                            if (s_q.depth != VIU_STK_FULL) begin
                                s_d.stack[s_q.depth[2:0]] = {best_idx, best_prio};
                                s_d.depth = s_q.depth + 4'h1;
                            end
                        end else begin
                            s_d.rdata = s_q.spur_vec;
                            s_d.spur  = 1'b1;
                        end
                    end
                    VIU_OFF_FVEC: begin
                        if (fack) begin
                            s_d.rdata = s_q.handler_address[0];
                            clr_m[0]  = 1'b1;
                        end else begin
                            s_d.rdata = s_q.spur_vec;
                            s_d.spur  = 1'b1;
                        end
                    end
                    VIU_OFF_CUR: begin
                        if (s_q.depth != 4'h0 && !s_q.spur) begin
                            s_d.rdata = {27'h0, cur_src};
                        end else begin
                            s_d.rdata = VIU_WORD_RST;
                        end
                    end
                    VIU_OFF_PEND: s_d.rdata = pend;
                    VIU_OFF_ENA:  s_d.rdata = s_q.ena;
                    VIU_OFF_CORE: s_d.rdata = {30'h0, ~s_q.irq_n, ~s_q.fiq_n};
                    VIU_OFF_SPUR: s_d.rdata = s_q.spur_vec;
                    default:      s_d.rdata = VIU_WORD_RST;
                endcase
            end
        end

        // New edge beats a same-cycle clear; level sources keep no latch
        s_d.edge_pend = ((s_q.edge_pend & ~clr_m) | set_m) & is_edge;

        // A spurious read blocks both lines from the very next cycle
        s_d.irq_n = ~(irq_want && !s_d.spur);
        s_d.fiq_n = ~(fiq_want && !s_d.spur);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q       <= '0;
            s_q.irq_n <= 1'b1;
            s_q.fiq_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data               = s_q.rdata;
    assign normal_request_line_n = s_q.irq_n;
    assign fast_request_line_n   = s_q.fiq_n;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    property p_fast_vec;
        rd_en && addr == VIU_OFF_FVEC && !fast_request_line_n && fiq_want
        |=> rd_data == $past(s_q.handler_address[0]);
    endproperty
    a_fast_vec: assert property (p_fast_vec) else $error("fast vector wrong");

    property p_fast_clr;
        rd_en && addr == VIU_OFF_FVEC && !fast_request_line_n && fiq_want &&
        s_q.trig[0][0] && !(wr_en) && edge_det[0] == 1'b0
        |=> !s_q.edge_pend[0] || edge_det[0];
    endproperty
    a_fast_clr: assert property (p_fast_clr) else $error("fast edge not cleared");

    property p_drop;
        !irq_want && !fiq_want |=> normal_request_line_n && fast_request_line_n;
    endproperty
    a_drop: assert property (p_drop) else $error("line held without source");

    property p_nspur;
        rd_en && addr == VIU_OFF_NVEC && normal_request_line_n
        |=> rd_data == $past(s_q.spur_vec) && s_q.spur;
    endproperty
    a_nspur: assert property (p_nspur) else $error("no spurious on normal");

    property p_fspur;
        rd_en && addr == VIU_OFF_FVEC && fast_request_line_n
        |=> rd_data == $past(s_q.spur_vec);
    endproperty
    a_fspur: assert property (p_fspur) else $error("no spurious on fast");

    property p_hold;
        s_q.spur |=> normal_request_line_n && fast_request_line_n;
    endproperty
    a_hold: assert property (p_hold) else $error("line during spurious");

    property p_cur_zero;
        s_q.spur && rd_en && addr == VIU_OFF_CUR |=> rd_data == 32'h0000_0000;
    endproperty
    a_cur_zero: assert property (p_cur_zero) else $error("status not zero");

    property p_core;
        rd_en && addr == VIU_OFF_CORE
        |=> rd_data[1:0] == {~$past(normal_request_line_n), ~$past(fast_request_line_n)};
    endproperty
    a_core: assert property (p_core) else $error("core status wrong");

    property p_enable;
        wr_en && addr == VIU_OFF_ENCMD |=> (s_q.ena & $past(wdata)) == $past(wdata);
    endproperty
    a_enable: assert property (p_enable) else $error("enable not set");

    property p_pop;
        wr_en && addr == VIU_OFF_EOS && !s_q.spur && s_q.depth != 4'h0 && !rd_en
        |=> s_q.depth == $past(s_q.depth) - 4'h1;
    endproperty
    a_pop: assert property (p_pop) else $error("no pop");

    property p_cmd_zero;
        rd_en && addr == VIU_OFF_ENCMD |=> rd_data == 32'h0000_0000;
    endproperty
    a_cmd_zero: assert property (p_cmd_zero) else $error("command reads nonzero");

    property p_nvec_ack;
        rd_en && addr == VIU_OFF_NVEC && !normal_request_line_n && irq_want
        |=> rd_data == $past(s_q.handler_address[best_idx]);
    endproperty
    a_nvec_ack: assert property (p_nvec_ack) else $error("normal vector wrong");

    property p_push;
        rd_en && addr == VIU_OFF_NVEC && !normal_request_line_n && irq_want &&
        s_q.depth != VIU_STK_FULL
        |=> s_q.depth == $past(s_q.depth) + 4'h1 && cur_prio == $past(best_prio);
    endproperty
    a_push: assert property (p_push) else $error("level not pushed");

    property p_restore;
        wr_en && addr == VIU_OFF_EOS && !s_q.spur && s_q.depth > 4'h1
        |=> cur_prio == $past(s_q.stack[top_idx - 3'h1][2:0]);
    endproperty
    a_restore: assert property (p_restore) else $error("level not restored");

    property p_cur_src;
        rd_en && addr == VIU_OFF_CUR && !s_q.spur && s_q.depth != 4'h0
        |=> rd_data == {27'h0, $past(cur_src)};
    endproperty
    a_cur_src: assert property (p_cur_src) else $error("current source wrong");

    property p_pend_rd;
        rd_en && addr == VIU_OFF_PEND |=> rd_data == $past(pend);
    endproperty
    a_pend_rd: assert property (p_pend_rd) else $error("pending view wrong");

    property p_mask_rd;
        rd_en && addr == VIU_OFF_ENA |=> rd_data == $past(s_q.ena);
    endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("enable view wrong");

    property p_disable;
        wr_en && addr == VIU_OFF_DISCMD |=> (s_q.ena & $past(wdata)) == 32'h0000_0000;
    endproperty
    a_disable: assert property (p_disable) else $error("disable not cleared");

    property p_zero_bits;
        wr_en && (addr == VIU_OFF_ENCMD || addr == VIU_OFF_DISCMD)
        |=> ((s_q.ena ^ $past(s_q.ena)) & ~$past(wdata)) == 32'h0000_0000;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("zero bit changed a flag");

    property p_mode_rd;
        rd_en && addr < VIU_OFF_HNDL |=> rd_data[31:7] == 25'h0 && rd_data[4:3] == 2'h0;
    endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("mode reserved bits set");

    property p_int_trig;
        rd_en && addr < VIU_OFF_HNDL && !VIU_EXT_MASK[addr[6:2]] |=> !rd_data[6];
    endproperty
    a_int_trig: assert property (p_int_trig) else $error("internal trigger bit set");

    property p_prio_wr;
        wr_en && addr < VIU_OFF_HNDL |=> s_q.prio[$past(addr[6:2])] == $past(wdata[2:0]);
    endproperty
    a_prio_wr: assert property (p_prio_wr) else $error("urgency not stored");

    property p_vect_wr;
        wr_en && addr >= VIU_OFF_HNDL && addr < VIU_OFF_NVEC
        |=> s_q.handler_address[$past(addr[6:2])] == $past(wdata);
    endproperty
    a_vect_wr: assert property (p_vect_wr) else $error("handler not stored");

    property p_spur_eos;
        wr_en && addr == VIU_OFF_EOS && s_q.spur
        |=> !s_q.spur && s_q.depth == $past(s_q.depth);
    endproperty
    a_spur_eos: assert property (p_spur_eos) else $error("hold not released");

    property p_fast_drop;
        rd_en && addr == VIU_OFF_FVEC && !fast_request_line_n && fiq_want &&
        s_q.trig[0][0] && !edge_det[0]
        |=> ##1 fast_request_line_n;
    endproperty
    a_fast_drop: assert property (p_fast_drop) else $error("fast line kept after ack");

    property p_fast_level;
        !s_q.trig[0][0] && pend[0] && s_q.ena[0] && !s_q.spur && !rd_en
        |=> !fast_request_line_n;
    endproperty
    a_fast_level: assert property (p_fast_level) else $error("level fast line dropped");

    c_spur:   cover property (s_q.spur ##1 !s_q.spur);
    c_nest:   cover property (s_q.depth == 4'h2);
    c_fast:   cover property (rd_en && addr == VIU_OFF_FVEC && !fast_request_line_n);
    c_level_fast: cover property (!fast_request_line_n && !s_q.trig[0][0]);
    c_pop_nest:   cover property (wr_en && addr == VIU_OFF_EOS && s_q.depth == 4'h2);
endmodule

//--- dv/viu_core_model.sv
`timescale 1ns/1ps
module viu_core_model (
    input  wire logic       ref_clk,               // Clock
    input  wire logic       rst_b,                 // Reset, low
    input  wire logic       normal_request_line_n, // Normal line
    input  wire logic       fast_request_line_n,   // Fast line
    output logic      [7:0] norm_cnt_q,            // Normal entries
    output logic      [7:0] fast_cnt_q             // Fast entries
);
    logic norm_q;
    logic fast_q;
    // Entry counts on each new assertion; a later drop cannot undo it
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            norm_q     <= 1'b1;
            fast_q     <= 1'b1;
            norm_cnt_q <= 8'h00;
            fast_cnt_q <= 8'h00;
        end else begin
            norm_q <= normal_request_line_n;
            fast_q <= fast_request_line_n;
            if (norm_q && !normal_request_line_n) begin
                norm_cnt_q <= norm_cnt_q + 8'h01;
            end
            if (fast_q && !fast_request_line_n) begin
                fast_cnt_q <= fast_cnt_q + 8'h01;
            end
        end
    end
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench
    import viu_pkg::*;
;
    typedef struct packed {logic [8:0] a; logic [31:0] w; logic [31:0] e;} viu_rw_t;
    logic        ref_clk;
    logic        rst_b;
    logic [8:0]  addr;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] wdata;
    logic [31:0] rd_data;
    logic [31:0] src_in;
    logic        norm_n;
    logic        fast_n;
    logic [7:0]  norm_cnt;
    logic [7:0]  fast_cnt;
    logic [31:0] d;
    int          failures;
    int          check_count;
    logic [8:0]  zero_tab [10] = '{9'h000, 9'h07c, 9'h080, 9'h0fc, 9'h100,
                                   9'h104, 9'h108, 9'h110, 9'h114, 9'h134};
    viu_rw_t     rw_tab [12] = '{
        '{9'h07c, 32'h7, 32'h7}, '{9'h0fc, 32'ha5a5_5a5a, 32'ha5a5_5a5a},
        '{9'h070, 32'h67, 32'h67}, '{9'h110, 32'hffff_ffff, 32'h0},
        '{9'h134, 32'hdead_0134, 32'hdead_0134}, '{9'h00c, 32'h2, 32'h2},
        '{9'h08c, 32'h1000_0300, 32'h1000_0300}, '{9'h014, 32'h67, 32'h27},
        '{9'h094, 32'h1000_0500, 32'h1000_0500}, '{9'h018, 32'h1, 32'h1},
        '{9'h098, 32'h1000_0600, 32'h1000_0600}, '{9'h024, 32'h20, 32'h20}};

    viu_top i_viu_top (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wr_en(wr_en),
        .rd_en(rd_en), .wdata(wdata), .rd_data(rd_data), .src_in(src_in),
        .normal_request_line_n(norm_n), .fast_request_line_n(fast_n));
    viu_core_model i_viu_core_model (.ref_clk(ref_clk), .rst_b(rst_b),
        .normal_request_line_n(norm_n), .fast_request_line_n(fast_n),
        .norm_cnt_q(norm_cnt), .fast_cnt_q(fast_cnt));

    task chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task chk1(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask
    task wr(input logic [8:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask
    task rd(input logic [8:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        v = rd_data;
    endtask
    task rchk(input logic [8:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        chk32($sformatf("register %h", a), e, v);
    endtask
    task setsrc(input int i, input logic v);
        @(posedge ref_clk);
        src_in[i] <= v;
    endtask
    // Bounded wait; a line that never settles is reported, not hung on
    task wait_ln(input logic f, input logic v);
        #1;
        for (int n = 0; n < 8 && (f ? fast_n : norm_n) !== v; n++) begin
            @(posedge ref_clk);
            #1;
        end
        chk1(f ? "fast line" : "normal line", v, f ? fast_n : norm_n);
    endtask
    task close_out;
        $display("Comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        close_out();
    end

    initial begin
        rst_b = 1'b0;
        addr = 9'h000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        wdata = 32'h0;
        src_in = 32'h3000_0001;
        failures = 0;
        check_count = 0;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        foreach (zero_tab[i]) rchk(zero_tab[i], 32'h0);
        wr(VIU_OFF_EOS, 32'h0);
        foreach (rw_tab[i]) begin
            wr(rw_tab[i].a, rw_tab[i].w);
            rchk(rw_tab[i].a, rw_tab[i].e);
        end
        for (int a = 'h118; a <= 'h130; a += 4) rchk(9'(a), 32'h0);
        wr(VIU_OFF_ENCMD, 32'h68);
        wr(VIU_OFF_DISCMD, 32'h20);
        rchk(VIU_OFF_ENA, 32'h48);
        wr(VIU_OFF_ENCMD, 32'h20);
        rchk(VIU_OFF_ENA, 32'h68);
        setsrc(3, 1'b1);
        wait_ln(1'b0, 1'b0);
        rchk(VIU_OFF_PEND, 32'h8);
        rchk(VIU_OFF_CORE, 32'h2);
        rchk(VIU_OFF_NVEC, 32'h1000_0300);
        rchk(VIU_OFF_CUR, 32'h3);
        wait_ln(1'b0, 1'b1);
        setsrc(5, 1'b1);
        setsrc(5, 1'b0);
        wait_ln(1'b0, 1'b0);
        rchk(VIU_OFF_NVEC, 32'h1000_0500);
        rchk(VIU_OFF_CUR, 32'h5);
        rchk(VIU_OFF_PEND, 32'h8);
        wr(VIU_OFF_EOS, 32'h0);
        rchk(VIU_OFF_CUR, 32'h3);
        setsrc(3, 1'b0);
        wr(VIU_OFF_EOS, 32'h0);
        rchk(VIU_OFF_CUR, 32'h0);
        setsrc(6, 1'b1);
        wait_ln(1'b0, 1'b0);
        setsrc(6, 1'b0);
        wait_ln(1'b0, 1'b1);
        rchk(VIU_OFF_NVEC, 32'hdead_0134);
        rchk(VIU_OFF_CUR, 32'h0);
        setsrc(6, 1'b1);
        repeat (6) @(posedge ref_clk);
        #1;
        chk1("normal line held", 1'b1, norm_n);
        wr(VIU_OFF_EOS, 32'h0);
        wait_ln(1'b0, 1'b0);
        rchk(VIU_OFF_NVEC, 32'h1000_0600);
        setsrc(6, 1'b0);
        wr(VIU_OFF_EOS, 32'h0);
        wr(VIU_OFF_SETCMD, 32'h200);
        rchk(VIU_OFF_PEND, 32'h200);
        chk1("normal line", 1'b1, norm_n);
        wr(VIU_OFF_CLRCMD, 32'h200);
        rchk(VIU_OFF_PEND, 32'h0);
        setsrc(0, 1'b0);
        wr(9'h000, 32'h40);
        wr(9'h080, 32'hf000_0000);
        wr(VIU_OFF_ENCMD, 32'h1);
        setsrc(0, 1'b1);
        wait_ln(1'b1, 1'b0);
        rchk(VIU_OFF_FVEC, 32'hf000_0000);
        repeat (3) @(posedge ref_clk);
        #1;
        chk1("fast line level", 1'b0, fast_n);
        setsrc(0, 1'b0);
        wait_ln(1'b1, 1'b1);
        wr(9'h000, 32'h60);
        setsrc(0, 1'b1);
        wait_ln(1'b1, 1'b0);
        rchk(VIU_OFF_CORE, 32'h1);
        rchk(VIU_OFF_FVEC, 32'hf000_0000);
        wait_ln(1'b1, 1'b1);
        rchk(VIU_OFF_FVEC, 32'hdead_0134);
        wr(VIU_OFF_EOS, 32'h0);
        chk32("normal entries", 32'h4, {24'h0, norm_cnt});
        chk32("fast entries", 32'h2, {24'h0, fast_cnt});
        for (int t = 0; t < 4; t++) begin
            wr(VIU_OFF_CLRCMD, 32'h1000_0000);
            wr(9'h070, {25'h0, t[1:0], 5'h00});
            setsrc(28, ~t[1]);
            repeat (4) @(posedge ref_clk);
            rd(VIU_OFF_PEND, d);
            chk1("ext idle", 1'b0, d[28]);
            setsrc(28, t[1]);
            repeat (4) @(posedge ref_clk);
            rd(VIU_OFF_PEND, d);
            chk1("ext active", 1'b1, d[28]);
            setsrc(28, ~t[1]);
            repeat (4) @(posedge ref_clk);
            rd(VIU_OFF_PEND, d);
            chk1("ext latched", t[0], d[28]);
        end
        close_out();
    end
endmodule
